// file: rtl/tmc_defines.svh
// constants of the trigger matching channel
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
`define TMC_TS_W          48
`define TMC_SAMPLE_W      14
`define TMC_DELAY_LEN     32
`define TMC_EDGE_COUNT    16
`define TMC_EVQ_DEPTH     16
`define TMC_TSQ_DEPTH     8
`define TMC_ENQ_DEPTH     16
`define TMC_FILT_LEN      8
`define TMC_LATENCY_RST   48'h0000_0000_0040
`define TMC_WINDOW_RST    48'h0000_0000_0010
`endif

// file: rtl/tmc_pkg.sv
// types of the trigger matching channel
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_IDLE,
    TMC_MATCH
  } tmc_match_state_t;
  typedef enum logic [1:0] {
    TMC_ACCEPT = 2'h1,
    TMC_REJECT = 2'h2
  } tmc_outcome_t;
endpackage

// file: rtl/tmc_queue.sv
// synchronous fifo memory with registered read data
module tmc_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  empty,
  output logic                  full,
  output logic      [WIDTH-1:0] head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  logic [WIDTH-1:0] rd_data_ff;
  wire              do_wr = wr_en && !full;
  wire              do_rd = rd_en && !empty;

  assign empty   = (wp_ff == rp_ff);
  assign full    = (wp_ff[AW-1:0] == rp_ff[AW-1:0]) && (wp_ff[AW] != rp_ff[AW]);
  assign head    = mem[rp_ff[AW-1:0]];
  assign rd_data = rd_data_ff;

  always_ff @(posedge sys_clk) begin
    if (clk_en && do_wr) begin
      mem[wp_ff[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wp_ff      <= '0;
      rp_ff      <= '0;
      rd_data_ff <= '0;
    end else if (clk_en) begin
      if (do_wr) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (do_rd) begin
        rp_ff      <= rp_ff + 1'b1;
        rd_data_ff <= mem[rp_ff[AW-1:0]];
      end
    end
  end
endmodule

// file: rtl/tmc_channel.sv
// one readout channel: delay line, energy filter, edge capture, trigger matching
//
// Contract
// - every sample feeds delay line and filter
// - filter energy written into energy queue
// - local trigger copies fixed sample run
// - validation stores current time in queue
// - engine compares validation and event tags
// - match accepts a window of times
// - window starts at time minus latency
// - in-window events go to readout
// - events older than window are dropped
// - events newer than window stay queued
// - timestamp and tags are 48 bits
// - each decision reported to processing host
`include "tmc_defines.svh"
module tmc_channel #(
  parameter int TS_W       = `TMC_TS_W,
  parameter int SAMPLE_W   = `TMC_SAMPLE_W,
  parameter int DELAY_LEN  = `TMC_DELAY_LEN,
  parameter int EDGE_COUNT = `TMC_EDGE_COUNT,
  parameter int EVQ_DEPTH  = `TMC_EVQ_DEPTH,
  parameter int TSQ_DEPTH  = `TMC_TSQ_DEPTH,
  parameter int ENQ_DEPTH  = `TMC_ENQ_DEPTH,
  parameter int FILT_LEN   = `TMC_FILT_LEN
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                clk_en,
  input  wire logic [TS_W-1:0]     global_time,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                local_trigger,
  input  wire logic                validation_in,
  input  wire logic [TS_W-1:0]     trigger_latency,
  input  wire logic [TS_W-1:0]     match_window,
  input  wire logic                energy_rd,
  output logic                     energy_valid,
  output logic [SAMPLE_W+7:0]      energy_data,
  output logic                     readout_valid,
  output logic [SAMPLE_W-1:0]      readout_sample,
  output logic [TS_W-1:0]          readout_tag,
  output logic                     readout_last,
  output logic                     outcome_valid,
  output tmc_pkg::tmc_outcome_t    outcome,
  output logic [TS_W-1:0]          outcome_tag,
  input  wire logic                outcome_ack,
  output logic                     event_overflow
);
  import tmc_pkg::*;

  localparam int EW  = SAMPLE_W + 8;
  localparam int CW  = $clog2(EDGE_COUNT + 1);
  localparam int EVW = 1 + SAMPLE_W + TS_W;

  // --------------------------------------------------------------
  // wrap-safe time compare
  // --------------------------------------------------------------
  function automatic logic ts_before(input logic [TS_W-1:0] a, input logic [TS_W-1:0] b);
    logic [TS_W-1:0] d;
    d = a - b;
    return d[TS_W-1];
  endfunction

  // --------------------------------------------------------------
  // input pipeline, delay line, energy filter
  // --------------------------------------------------------------
  logic [SAMPLE_W-1:0] dly_ff [DELAY_LEN];
  logic [SAMPLE_W-1:0] flt_ff [FILT_LEN];
  logic [EW-1:0]       sum_ff;
  logic                en_wr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dly_ff <= '{default: '0};
      flt_ff <= '{default: '0};
      sum_ff <= '0;
    end else if (clk_en) begin
      dly_ff[0] <= sample_in;
      flt_ff[0] <= sample_in;
      for (int i = 1; i < DELAY_LEN; i++) dly_ff[i] <= dly_ff[i-1];
      for (int i = 1; i < FILT_LEN; i++) flt_ff[i] <= flt_ff[i-1];
      sum_ff <= sum_ff + EW'(sample_in) - EW'(flt_ff[FILT_LEN-1]);
    end
  end

  // energy value sampled a filter length (capped at EDGE_COUNT cycles) after the latest local trigger; triggers within that wait share one value
  logic [CW-1:0] en_dly_ff;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_dly_ff <= '0;
    end else if (clk_en) begin
      if (local_trigger) begin
        en_dly_ff <= CW'(FILT_LEN < EDGE_COUNT ? FILT_LEN : EDGE_COUNT);
      end else if (en_dly_ff != '0) begin
        en_dly_ff <= en_dly_ff - 1'b1;
      end
    end
  end
  assign en_wr = (en_dly_ff == CW'(1));
  logic en_empty;

  tmc_queue #(.WIDTH(EW), .DEPTH(ENQ_DEPTH)) u_energy_queue (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .wr_en   (en_wr),
    .wr_data (sum_ff),
    .rd_en   (energy_rd),
    .rd_data (energy_data),
    .empty   (en_empty),
    .full    (),
    .head    ()
  );
  assign energy_valid = !en_empty;

  // --------------------------------------------------------------
  // edge capture into sample event queue
  // --------------------------------------------------------------
  logic [TS_W-1:0] trig_tag_ff;
  logic [CW-1:0]   cap_cnt_ff;
  wire             cap_start = local_trigger && (cap_cnt_ff == '0);
  wire             cap_busy  = (cap_cnt_ff != '0);
  wire             cap_last  = (cap_cnt_ff == CW'(1));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cap_cnt_ff  <= '0;
      trig_tag_ff <= '0;
    end else if (clk_en) begin
      if (cap_start) begin
        cap_cnt_ff  <= CW'(EDGE_COUNT);
        trig_tag_ff <= global_time;
      end else if (cap_busy) begin
        cap_cnt_ff <= cap_cnt_ff - 1'b1;
      end
    end
  end

  logic            evq_full;
  logic            evq_empty;
  logic [EVW-1:0]  evq_head;
  logic            evq_rd;
  wire  [EVW-1:0]  evq_wdata = {cap_last, dly_ff[DELAY_LEN-1], trig_tag_ff};
  logic            ovf_ff;

  tmc_queue #(.WIDTH(EVW), .DEPTH(EVQ_DEPTH * EDGE_COUNT)) u_sample_event_queue (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .wr_en   (cap_busy),
    .wr_data (evq_wdata),
    .rd_en   (evq_rd),
    .rd_data (),
    .empty   (evq_empty),
    .full    (evq_full),
    .head    (evq_head)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovf_ff <= 1'b0;
    end else if (clk_en && cap_busy && evq_full) begin
      ovf_ff <= 1'b1;
    end
  end
  assign event_overflow = ovf_ff;

  // --------------------------------------------------------------
  // validation time queue
  // --------------------------------------------------------------
  logic            tsq_empty;
  logic [TS_W-1:0] tsq_head;
  logic            tsq_rd;

  tmc_queue #(.WIDTH(TS_W), .DEPTH(TSQ_DEPTH)) u_validation_time_queue (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .wr_en   (validation_in),
    .wr_data (global_time),
    .rd_en   (tsq_rd),
    .rd_data (),
    .empty   (tsq_empty),
    .full    (),
    .head    (tsq_head)
  );

  // --------------------------------------------------------------
  // matching engine
  // --------------------------------------------------------------
  tmc_match_state_t st_ff;
  logic [TS_W-1:0]  win_start_ff;
  logic [TS_W-1:0]  win_end_ff;
  logic             rsv_ff;
  logic             out_valid_ff;
  tmc_outcome_t     out_ff;
  logic [TS_W-1:0]  out_tag_ff;
  logic             ro_valid_ff;
  logic [SAMPLE_W-1:0] ro_sample_ff;
  logic [TS_W-1:0]  ro_tag_ff;
  logic             ro_last_ff;

  wire [TS_W-1:0] ev_tag   = evq_head[TS_W-1:0];
  wire            ev_last  = evq_head[EVW-1];
  wire            ev_old   = ts_before(ev_tag, win_start_ff);
  wire            ev_new   = !ts_before(ev_tag, win_end_ff);
  wire            ev_in    = !ev_old && !ev_new;
  wire            host_ok  = !out_valid_ff || outcome_ack;
  wire            ev_ready = !evq_empty && !(cap_busy && ev_tag == trig_tag_ff);
  wire            in_match = (st_ff == TMC_MATCH);
  wire            step     = in_match && ev_ready && host_ok && !ev_new;
  wire            done     = in_match && host_ok && (evq_empty || ev_new || !ev_ready);

  assign evq_rd = step;
  assign tsq_rd = (st_ff == TMC_IDLE) && !tsq_empty;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff        <= TMC_IDLE;
      win_start_ff <= '0;
      win_end_ff   <= '0;
      rsv_ff       <= 1'b0;
    end else if (clk_en) begin
      unique case (st_ff)
        TMC_IDLE: begin
          if (!tsq_empty) begin
            win_start_ff <= tsq_head - trigger_latency;
            win_end_ff   <= tsq_head - trigger_latency + match_window;
            st_ff        <= TMC_MATCH;
          end
        end
        TMC_MATCH: begin
          if (done && !(ev_ready && !ev_new && !evq_empty)) begin
            st_ff <= TMC_IDLE;
          end
        end
      endcase
    end
  end

  // outcome handshake and readout stream
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_valid_ff <= 1'b0;
      out_ff       <= TMC_REJECT;
      out_tag_ff   <= '0;
      ro_valid_ff  <= 1'b0;
      ro_sample_ff <= '0;
      ro_tag_ff    <= '0;
      ro_last_ff   <= 1'b0;
    end else if (clk_en) begin
      ro_valid_ff <= step && ev_in;
      if (step) begin
        ro_sample_ff <= evq_head[TS_W+SAMPLE_W-1:TS_W];
        ro_tag_ff    <= ev_tag;
        ro_last_ff   <= ev_last;
      end
      if (step && ev_last) begin
        out_valid_ff <= 1'b1;
        out_ff       <= ev_in ? TMC_ACCEPT : TMC_REJECT;
        out_tag_ff   <= ev_tag;
      end else if (outcome_ack) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  assign readout_valid  = ro_valid_ff;
  assign readout_sample = ro_sample_ff;
  assign readout_tag    = ro_tag_ff;
  assign readout_last   = ro_last_ff;
  assign outcome_valid  = out_valid_ff;
  assign outcome        = out_ff;
  assign outcome_tag    = out_tag_ff;
endmodule

// file: sim/tmc_channel_assertions.sv
// assertions on the ports of the trigger matching channel
module tmc_channel_assertions #(
  parameter int EDGE_COUNT = 16
) (
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input wire logic                  readout_valid,
  input wire logic [47:0]           readout_tag,
  input wire logic                  readout_last,
  input wire logic                  outcome_valid,
  input wire tmc_pkg::tmc_outcome_t outcome,
  input wire logic [47:0]           outcome_tag,
  input wire logic                  outcome_ack,
  input wire logic                  event_overflow
);
  import tmc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [7:0] seen_ff;
  always_ff @(posedge sys_clk) begin
    if (srst || (readout_valid && readout_last)) seen_ff <= 8'h00;
    else if (readout_valid) seen_ff <= seen_ff + 8'h01;
  end
  a_out_hold: assert property (outcome_valid && !outcome_ack |=>
    outcome_valid && $stable(outcome_tag)) else $error("outcome dropped");
  a_out_kind: assert property (outcome_valid && !outcome_ack |=>
    $stable(outcome)) else $error("outcome changed");
  a_out_code: assert property (outcome_valid |->
    outcome == TMC_ACCEPT || outcome == TMC_REJECT) else $error("bad outcome");
  a_ovf_sticky: assert property (event_overflow |=> event_overflow)
    else $error("overflow cleared");
  a_event_gap: assert property (readout_valid && !readout_last |=>
    readout_valid) else $error("gap in event");
  a_tag_same: assert property (readout_valid && !readout_last ##1
    readout_valid |-> $stable(readout_tag)) else $error("tag changed");
  a_event_len: assert property (readout_valid && readout_last |->
    seen_ff == 8'(EDGE_COUNT - 1)) else $error("event length");
  a_last_accept: assert property (readout_valid && readout_last |->
    ##[0:1] (outcome_valid && outcome == TMC_ACCEPT)) else $error("no accept");
  c_accept: cover property (outcome_valid && outcome_ack && outcome == TMC_ACCEPT);
  c_reject: cover property (outcome_valid && outcome_ack && outcome == TMC_REJECT);
  c_wait: cover property (outcome_valid && !outcome_ack ##1 outcome_valid);
  c_ovf: cover property ($rose(event_overflow));
endmodule
bind tmc_channel tmc_channel_assertions #(.EDGE_COUNT(EDGE_COUNT)) chk_u (
  .sys_clk(sys_clk), .srst(srst), .readout_valid(readout_valid),
  .readout_tag(readout_tag), .readout_last(readout_last),
  .outcome_valid(outcome_valid), .outcome(outcome), .outcome_tag(outcome_tag),
  .outcome_ack(outcome_ack), .event_overflow(event_overflow));

// file: sim/tmc_host_model.sv
// processing host model: acknowledges decisions, drains energy queue
module tmc_host_model (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic outcome_valid,
  input  wire logic energy_valid,
  output logic      outcome_ack,
  output logic      energy_rd,
  output logic [7:0] energy_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 11;
  logic [1:0] wait_ff = 2'h0;
  initial begin
    outcome_ack = 1'b0;
    energy_rd = 1'b0;
    energy_cnt = 8'h00;
  end
  always @(posedge sys_clk) begin
    if (srst) begin
      outcome_ack <= #1 1'b0;
      energy_rd <= #1 1'b0;
      energy_cnt <= 8'h00;
    end else begin
      // ack after a random wait of 0 to 3 cycles
      if (outcome_valid && !outcome_ack && wait_ff == 2'h0) begin
        outcome_ack <= #1 1'b1;
        wait_ff <= 2'($random(seed));
      end else begin
        outcome_ack <= #1 1'b0;
        if (outcome_valid && wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
      end
      energy_rd <= #1 energy_valid && !energy_rd;
      if (energy_rd && energy_valid) energy_cnt <= energy_cnt + 8'h01;
    end
  end
endmodule

// file: sim/tmc_channel_tb.sv
// self-checking bench of the trigger matching channel
`include "tmc_defines.svh"
module tmc_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmc_pkg::*;
  localparam int NEV = 8;
  localparam int WIN = 16;
  localparam logic [47:0] LAT = 48'h0000_0000_0040;
  logic sys_clk = 1'b0, srst = 1'b1, local_trigger = 1'b0, validation_in = 1'b0;
  logic [47:0] global_time = 48'hffff_ffff_ff80;
  logic clk_en = 1'b1, en_pop = 1'b0;
  logic [47:0] cur_t;
  logic [21:0] exp_en [$];
  logic outcome_ack, energy_rd, energy_valid, readout_valid, readout_last;
  logic outcome_valid, event_overflow;
  logic [21:0] energy_data;
  logic [13:0] readout_sample, last_s;
  logic [47:0] readout_tag, outcome_tag, t_ev [NEV];
  logic [7:0] energy_cnt;
  tmc_outcome_t outcome;
  int seed = 11, error_cnt = 0, total_checks = 0, cyc = 0, nro = 0;
  int d_ev [NEV];
  logic sel [NEV];
  logic [47:0] exp_ro [$];
  logic [49:0] exp_out [$];
  always #12.5 sys_clk = ~sys_clk;
  tmc_channel dut_u (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .global_time(global_time),
    .sample_in(global_time[13:0]), .local_trigger(local_trigger),
    .validation_in(validation_in), .trigger_latency(LAT), .match_window(48'(WIN)),
    .energy_rd(energy_rd), .energy_valid(energy_valid), .energy_data(energy_data),
    .readout_valid(readout_valid), .readout_sample(readout_sample),
    .readout_tag(readout_tag), .readout_last(readout_last),
    .outcome_valid(outcome_valid), .outcome(outcome), .outcome_tag(outcome_tag),
    .outcome_ack(outcome_ack), .event_overflow(event_overflow));
  tmc_host_model host_u (
    .sys_clk(sys_clk), .srst(srst), .outcome_valid(outcome_valid),
    .energy_valid(energy_valid), .outcome_ack(outcome_ack),
    .energy_rd(energy_rd), .energy_cnt(energy_cnt));
  task automatic chk(input logic [49:0] seen, input logic [49:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic tmc_outcome_t exp_kind(input int i);
    return (sel[i] && d_ev[i] < WIN) ? TMC_ACCEPT : TMC_REJECT;
  endfunction
  // moving sum of the eight samples taken from the trigger edge on
  function automatic logic [21:0] exp_energy(input logic [47:0] t);
    logic [21:0] s;
    logic [13:0] v;
    s = '0;
    for (int k = 0; k < 8; k++) begin
      v = t[13:0] + 14'(k);
      s = s + 22'(v);
    end
    return s;
  endfunction
  task automatic step(input logic extra_trig);
    @(posedge sys_clk);
    #1;
    global_time = global_time + 48'h1;
    local_trigger = extra_trig;
    validation_in = 1'b0;
    for (int i = 0; i < NEV; i++) begin
      if (global_time == t_ev[i]) local_trigger = 1'b1;
      if (sel[i] && global_time == t_ev[i] + LAT - 48'(d_ev[i])) validation_in = 1'b1;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
    if (en_pop) chk(50'(energy_data), 50'(exp_en.pop_front()));
    en_pop = !srst && clk_en && energy_rd && energy_valid;
    if (!srst && clk_en && local_trigger) exp_en.push_back(exp_energy(global_time));
    if (!srst && readout_valid) begin
      cur_t = exp_ro.pop_front();
      chk(50'(readout_tag), 50'(cur_t));
      if (nro > 0) chk(50'(readout_sample), 50'(14'(last_s + 14'h1)));
      else chk(50'(readout_sample), 50'(14'(cur_t - 48'(`TMC_DELAY_LEN - 1))));
      chk(50'(readout_last), 50'(nro == 15));
      last_s = readout_sample;
      nro = readout_last ? 0 : nro + 1;
    end
    if (!srst && outcome_valid && outcome_ack)
      chk({outcome, outcome_tag}, exp_out.pop_front());
  end
  initial begin
    for (int i = 0; i < NEV; i++) begin
      t_ev[i] = global_time + 48'(100 + 40 * i + {$random(seed)} % 6);
      d_ev[i] = (i == 0) ? 0 : (i == 1) ? WIN - 1 : (i == 2) ? WIN :
                (i == NEV - 1) ? {$random(seed)} % WIN : {$random(seed)} % 17;
      sel[i] = (i < 3 || i == NEV - 1) ? 1'b1 : 1'($random(seed));
      if (exp_kind(i) == TMC_ACCEPT) repeat (16) exp_ro.push_back(t_ev[i]);
      exp_out.push_back({exp_kind(i), t_ev[i]});
    end
    repeat (6) step(1'b0);
    srst = 1'b0;
    repeat (520) step(1'b0);
    for (int k = 0; k < 200 && exp_out.size() > 0; k++) step(1'b0);
    chk(50'(exp_out.size()), 50'h0);
    chk(50'(exp_ro.size()), 50'h0);
    clk_en = 1'b0;
    repeat (4) step(1'b1);
    step(1'b0);
    clk_en = 1'b1;
    repeat (12) step(1'b0);
    chk(50'(energy_cnt), 50'(NEV));
    chk(50'(event_overflow), 50'h0);
    for (int k = 0; k < 17 * 20 + 40; k++) step(k % 20 == 0 && k < 17 * 20);
    chk(50'(event_overflow), 50'h1);
    chk(50'(exp_en.size()), 50'h0);
    stop_test();
  end
endmodule
